// *** inc/bcm_defs.svh ***
// constants of the branch, call and move executor
`ifndef BCM_DEFS_SVH
`define BCM_DEFS_SVH

// ==========================================================
// timing and sizes
`define BCM_CLKS_PER_MC      4
`define BCM_IRAM_DEPTH       128

// ==========================================================
// opcodes
`define BCM_OP_JUMP_BIT_CLEAR     8'h30
`define BCM_OP_JUMP_CARRY_CLEAR   8'h50
`define BCM_OP_JUMP_ACC_NONZERO   8'h70
`define BCM_OP_JUMP_ACC_ZERO      8'h60
`define BCM_OP_LONG_CALL          8'h12
`define BCM_OP_LONG_JUMP          8'h02
`define BCM_OP_COPY_A_RN          8'hE8
`define BCM_OP_COPY_A_DIR         8'hE5
`define BCM_OP_COPY_A_IND         8'hE6
`define BCM_OP_COPY_A_IMM         8'h74
`define BCM_OP_COPY_RN_A          8'hF8
`define BCM_OP_COPY_RN_DIR        8'hA8
`define BCM_OP_COPY_RN_IMM        8'h78
`define BCM_OP_COPY_DIR_A         8'hF5
`define BCM_OP_COPY_DIR_RN        8'h88
`define BCM_OP_COPY_DIR_DIR       8'h85
`define BCM_OP_COPY_DIR_IND       8'h86
`define BCM_OP_COPY_DIR_IMM       8'h75
`define BCM_OP_COPY_IND_A         8'hF6
`define BCM_OP_COPY_IND_DIR       8'hA6
`define BCM_OP_COPY_IND_IMM       8'h76
`define BCM_OP_COPY_C_BIT         8'hA2
`define BCM_OP_COPY_BIT_C         8'h92
`define BCM_OP_LOAD_DATA_POINTER          8'h90
`define BCM_MASK_RN               8'hF8
`define BCM_MASK_RI               8'hFE

// ==========================================================
// special register addresses
`define BCM_SFR_ACC          8'hE0
`define BCM_SFR_B            8'hF0
`define BCM_SFR_PSW          8'hD0
`define BCM_SFR_SP           8'h81
`define BCM_SFR_DPL          8'h82
`define BCM_SFR_DPH          8'h83

// ==========================================================
// field positions and reset values
`define BCM_PSW_CY           7
`define BCM_PSW_BANK_HI      4
`define BCM_PSW_BANK_LO      3
`define BCM_BIT_RAM_HI       4'h2
`define BCM_SP_RST           8'h07
`define BCM_BYTE_RST         8'h00
`define BCM_PC_RST           16'h0000

`endif

// *** inc/bcm_pkg.sv ***
// types of the branch, call and move executor
`default_nettype none

package bcm_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    BCM_ST_OP,
    BCM_ST_B1,
    BCM_ST_B2,
    BCM_ST_EXEC,
    BCM_ST_PUSH2,
    BCM_ST_PAD
  } bcm_state_e;

  typedef logic [7:0]  bcm_byte_t;
  typedef logic [15:0] bcm_word_t;

endpackage : bcm_pkg

`default_nettype wire

// *** inc/bcm_ram_if.sv ***
// internal ram access bundle
`timescale 1ns/1ps
`default_nettype none

interface bcm_ram_if;
  logic [6:0] a_addr;
  logic [7:0] a_data;
  logic [6:0] b_addr;
  logic [7:0] b_data;
  logic       we;
  logic [6:0] w_addr;
  logic [7:0] w_data;

  modport ctrl (output a_addr, b_addr, we, w_addr, w_data, input a_data, b_data);
  modport mem  (input a_addr, b_addr, we, w_addr, w_data, output a_data, b_data);
endinterface : bcm_ram_if

`default_nettype wire

// *** hw/bcm_iram.sv ***
// internal data ram with two read ports and one write port
`timescale 1ns/1ps
`default_nettype none

module bcm_iram #(
  parameter int DEPTH = 128
) (
  // clock
  input  wire logic clk_i,
  // access
  bcm_ram_if.mem    ram
);

  logic [7:0] mem [DEPTH];

  assign ram.a_data = mem[ram.a_addr];
  assign ram.b_data = mem[ram.b_addr];

  always_ff @(posedge clk_i) begin
    if (ram.we) begin
      mem[ram.w_addr] <= ram.w_data;
    end
  end

endmodule : bcm_iram

`default_nettype wire

// *** hw/bcm_pacer.sv ***
// machine cycle pacer: marks the last core clock of an instruction
`timescale 1ns/1ps
`default_nettype none
`include "bcm_defs.svh"

module bcm_pacer (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       start_i,
  input  wire logic [2:0] cycles_i,
  output logic            done_o
);

  logic [4:0] cnt;
  logic [4:0] target;
  wire  [4:0] clks = 5'(cycles_i * `BCM_CLKS_PER_MC);

  assign done_o = (cnt == target);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 5'h00;
      target <= 5'h00;
    end else if (start_i) begin
      cnt    <= 5'h01;
      target <= 5'(clks - 5'h01);
    end else if (!done_o) begin
      cnt    <= 5'(cnt + 5'h01);
    end
  end

endmodule : bcm_pacer

`default_nettype wire

// *** hw/bcm_branch_call_move_executor.sv ***
// decode and execute of relative jumps, long call, long jump and moves
`timescale 1ns/1ps
`default_nettype none
`include "bcm_defs.svh"

module bcm_branch_call_move_executor (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              arst_n_i,
  // program memory
  output logic [15:0]            rom_addr_o,
  input  wire bcm_pkg::bcm_byte_t rom_data_i,
  // write port of special registers kept outside
  output logic                   sfr_we_o,
  output logic [7:0]             sfr_addr_o,
  output logic [7:0]             sfr_wdata_o,
  // core state
  output logic [15:0]            pc_o,
  output logic [7:0]             acc_o,
  output logic [7:0]             psw_o,
  output logic [7:0]             sp_o,
  output logic [15:0]            data_pointer_o,
  output logic                   insn_done_o
);
  import bcm_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // state
  bcm_state_e state;
  bcm_byte_t  opcode;
  bcm_byte_t  b1;
  bcm_byte_t  b2;
  logic [1:0] nbytes;
  bcm_word_t  pc;
  bcm_byte_t  acc;
  bcm_byte_t  breg;
  bcm_byte_t  psw;
  bcm_byte_t  sp;
  bcm_byte_t  data_pointer_high;
  bcm_byte_t  data_pointer_low;
  logic       mc_done;

  assign pc_o   = pc;
  assign acc_o  = acc;
  assign psw_o  = psw;
  assign sp_o   = sp;
  assign data_pointer_o = {data_pointer_high, data_pointer_low};

  // ==========================================================
  // opcode decode
  wire bcm_byte_t dec_op = (state == BCM_ST_OP) ? rom_data_i : opcode;
  wire bcm_byte_t op_rn  = dec_op & `BCM_MASK_RN;
  wire bcm_byte_t op_ri  = dec_op & `BCM_MASK_RI;

  wire op_jnb      = (dec_op == `BCM_OP_JUMP_BIT_CLEAR);
  wire op_jnc      = (dec_op == `BCM_OP_JUMP_CARRY_CLEAR);
  wire op_jnz      = (dec_op == `BCM_OP_JUMP_ACC_NONZERO);
  wire op_jz       = (dec_op == `BCM_OP_JUMP_ACC_ZERO);
  wire op_long_subroutine_call    = (dec_op == `BCM_OP_LONG_CALL);
  wire op_long_absolute_jump     = (dec_op == `BCM_OP_LONG_JUMP);
  wire op_a_rn     = (op_rn == `BCM_OP_COPY_A_RN);
  wire op_a_dir    = (dec_op == `BCM_OP_COPY_A_DIR);
  wire op_a_ind    = (op_ri == `BCM_OP_COPY_A_IND);
  wire op_a_imm    = (dec_op == `BCM_OP_COPY_A_IMM);
  wire op_rn_a     = (op_rn == `BCM_OP_COPY_RN_A);
  wire op_rn_dir   = (op_rn == `BCM_OP_COPY_RN_DIR);
  wire op_rn_imm   = (op_rn == `BCM_OP_COPY_RN_IMM);
  wire op_dir_a    = (dec_op == `BCM_OP_COPY_DIR_A);
  wire op_dir_rn   = (op_rn == `BCM_OP_COPY_DIR_RN);
  wire op_dir_dir  = (dec_op == `BCM_OP_COPY_DIR_DIR);
  wire op_dir_ind  = (op_ri == `BCM_OP_COPY_DIR_IND);
  wire op_dir_imm  = (dec_op == `BCM_OP_COPY_DIR_IMM);
  wire op_ind_a    = (op_ri == `BCM_OP_COPY_IND_A);
  wire op_ind_dir  = (op_ri == `BCM_OP_COPY_IND_DIR);
  wire op_ind_imm  = (op_ri == `BCM_OP_COPY_IND_IMM);
  wire op_c_bit    = (dec_op == `BCM_OP_COPY_C_BIT);
  wire op_bit_c    = (dec_op == `BCM_OP_COPY_BIT_C);
  wire op_data_pointer     = (dec_op == `BCM_OP_LOAD_DATA_POINTER);

  // ==========================================================
  // length and duration
  wire len3 = op_jnb | op_long_subroutine_call | op_long_absolute_jump | op_dir_dir | op_dir_imm | op_data_pointer;
  wire len2 = op_jnc | op_jnz | op_jz | op_a_imm | op_rn_imm | op_dir_rn
            | op_c_bit | op_bit_c | op_a_dir | op_rn_dir | op_dir_a
            | op_dir_ind | op_ind_dir | op_ind_imm;
  wire [1:0] insn_bytes = len3 ? 2'd3 : (len2 ? 2'd2 : 2'd1);
  wire [2:0] insn_cycles = (op_jnb | op_long_subroutine_call | op_long_absolute_jump) ? 3'd4 :
                           (op_jnc | op_jnz | op_jz)     ? 3'd3 :
                           {1'b0, insn_bytes};

  bcm_pacer u_pacer (
    .clk_i    (mclk_i),
    .rst_n_i  (rst_n),
    .start_i  (state == BCM_ST_OP),
    .cycles_i (insn_cycles),
    .done_o   (mc_done)
  );

  // ==========================================================
  // operand addressing
  bcm_ram_if ram_bus ();

  bcm_iram #(
    .DEPTH (`BCM_IRAM_DEPTH)
  ) u_iram (
    .clk_i (mclk_i),
    .ram   (ram_bus.mem)
  );

  wire [1:0]  bank     = psw[`BCM_PSW_BANK_HI:`BCM_PSW_BANK_LO];
  wire bcm_byte_t reg_addr = {3'b000, bank, opcode[2:0]};
  wire bcm_byte_t ri_val   = ram_bus.a_data;
  wire bcm_byte_t bit_byte = b1[7] ? {b1[7:3], 3'b000} : {`BCM_BIT_RAM_HI, b1[6:3]};
  wire bcm_byte_t bit_mask = 8'h01 << b1[2:0];

  wire is_bitop  = op_jnb | op_c_bit | op_bit_c;
  wire src_rn    = op_a_rn | op_dir_rn;
  wire src_ind   = op_a_ind | op_dir_ind;
  wire src_acc   = op_rn_a | op_dir_a | op_ind_a;
  wire src_imm1  = op_a_imm | op_rn_imm | op_ind_imm;
  wire src_imm2  = op_dir_imm;
  wire bcm_byte_t rd_dir = is_bitop ? bit_byte : (src_rn ? reg_addr : b1);

  assign ram_bus.a_addr = {2'b00, bank, 2'b00, opcode[0]};
  assign ram_bus.b_addr = src_ind ? ri_val[6:0] : rd_dir[6:0];

  wire bcm_byte_t sfr_rd =
      (rd_dir == `BCM_SFR_ACC) ? acc  :
      (rd_dir == `BCM_SFR_B)   ? breg :
      (rd_dir == `BCM_SFR_PSW) ? psw  :
      (rd_dir == `BCM_SFR_SP)  ? sp   :
      (rd_dir == `BCM_SFR_DPL) ? data_pointer_low  :
      (rd_dir == `BCM_SFR_DPH) ? data_pointer_high  : `BCM_BYTE_RST;
  wire bcm_byte_t dir_val = rd_dir[7] ? sfr_rd : ram_bus.b_data;
  wire bcm_byte_t src_val = src_acc  ? acc :
                            src_imm1 ? b1  :
                            src_imm2 ? b2  :
                            src_ind  ? ram_bus.b_data : dir_val;
  wire bit_val = |(dir_val & bit_mask);
  wire carry   = psw[`BCM_PSW_CY];
  wire bcm_byte_t bit_new = (dir_val & ~bit_mask) | (carry ? bit_mask : 8'h00);

  // ==========================================================
  // destination
  wire dst_acc  = op_a_rn | op_a_dir | op_a_ind | op_a_imm;
  wire dst_rn   = op_rn_a | op_rn_dir | op_rn_imm;
  wire dst_ind  = op_ind_a | op_ind_dir | op_ind_imm;
  wire dst_b2   = op_dir_dir;
  wire byte_mov = dst_acc | dst_rn | dst_ind | dst_b2 | op_dir_a
                | op_dir_rn | op_dir_imm | op_dir_ind;
  wire bcm_byte_t wr_addr = dst_acc  ? `BCM_SFR_ACC :
                            dst_rn   ? reg_addr :
                            dst_b2   ? b2 :
                            op_bit_c ? bit_byte : b1;
  wire bcm_byte_t wr_data = op_bit_c ? bit_new : src_val;

  wire in_exec  = (state == BCM_ST_EXEC);
  wire exec_wr  = in_exec & (byte_mov | op_bit_c);
  wire wr_ram   = exec_wr & (dst_ind | ~wr_addr[7]);
  wire wr_sfr   = exec_wr & ~dst_ind & wr_addr[7];
  wire wr_acc   = wr_sfr & (wr_addr == `BCM_SFR_ACC);
  wire wr_b     = wr_sfr & (wr_addr == `BCM_SFR_B);
  wire wr_psw   = wr_sfr & (wr_addr == `BCM_SFR_PSW);
  wire wr_sp    = wr_sfr & (wr_addr == `BCM_SFR_SP);
  wire wr_dpl   = wr_sfr & (wr_addr == `BCM_SFR_DPL);
  wire wr_dph   = wr_sfr & (wr_addr == `BCM_SFR_DPH);
  wire wr_ext   = wr_sfr & ~(wr_acc | wr_b | wr_psw | wr_sp | wr_dpl | wr_dph);

  // ==========================================================
  // stack pushes of the long call
  wire push_lo  = in_exec & op_long_subroutine_call;
  wire push_hi  = (state == BCM_ST_PUSH2);
  wire push_wr  = push_lo | push_hi;
  wire bcm_byte_t sp_inc = 8'(sp + 8'h01);

  assign ram_bus.we     = wr_ram | push_wr;
  assign ram_bus.w_addr = push_wr ? sp_inc[6:0] : (dst_ind ? ri_val[6:0] : wr_addr[6:0]);
  assign ram_bus.w_data = push_hi ? pc[15:8] : (push_lo ? pc[7:0] : wr_data);

  // ==========================================================
  // branch resolution
  wire bcm_byte_t rel8 = op_jnb ? b2 : b1;
  wire bcm_word_t rel_target = 16'(pc + {{8{rel8[7]}}, rel8});
  wire bcm_word_t abs_target = {b1, b2};
  wire take = (op_jnb & ~bit_val)
            | (op_jnc & ~carry)
            | (op_jnz & (|acc))
            | (op_jz  & ~(|acc));
  wire bcm_word_t exec_pc = take ? rel_target : (op_long_absolute_jump ? abs_target : pc);
  wire bcm_word_t pc_inc  = 16'(pc + 16'h0001);

  // ==========================================================
  // sequencer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= BCM_ST_OP;
      opcode     <= `BCM_BYTE_RST;
      b1         <= `BCM_BYTE_RST;
      b2         <= `BCM_BYTE_RST;
      nbytes     <= 2'd1;
      pc         <= `BCM_PC_RST;
      rom_addr_o <= `BCM_PC_RST;
    end else begin
      case (state)
        BCM_ST_OP: begin
          opcode     <= rom_data_i;
          nbytes     <= insn_bytes;
          pc         <= pc_inc;
          rom_addr_o <= pc_inc;
          state      <= (insn_bytes == 2'd1) ? BCM_ST_EXEC : BCM_ST_B1;
        end
        BCM_ST_B1: begin
          b1         <= rom_data_i;
          pc         <= pc_inc;
          rom_addr_o <= pc_inc;
          state      <= (nbytes == 2'd3) ? BCM_ST_B2 : BCM_ST_EXEC;
        end
        BCM_ST_B2: begin
          b2         <= rom_data_i;
          pc         <= pc_inc;
          state      <= BCM_ST_EXEC;
        end
        BCM_ST_EXEC: begin
          pc    <= exec_pc;
          state <= op_long_subroutine_call ? BCM_ST_PUSH2 : BCM_ST_PAD;
        end
        BCM_ST_PUSH2: begin
          pc    <= abs_target;
          state <= BCM_ST_PAD;
        end
        BCM_ST_PAD: begin
          if (mc_done) begin
            rom_addr_o <= pc;
            state      <= BCM_ST_OP;
          end
        end
        default: begin
          state <= BCM_ST_PAD;
        end
      endcase
    end
  end

  // ==========================================================
  // accumulator, b and flags
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc  <= `BCM_BYTE_RST;
      breg <= `BCM_BYTE_RST;
      psw  <= `BCM_BYTE_RST;
    end else begin
      if (wr_acc) begin
        acc <= wr_data;
      end
      if (wr_b) begin
        breg <= wr_data;
      end
      if (wr_psw) begin
        psw <= wr_data;
      end else if (in_exec & op_c_bit) begin
        psw[`BCM_PSW_CY] <= bit_val;
      end
    end
  end

  // ==========================================================
  // stack index and data pointer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sp  <= `BCM_SP_RST;
      data_pointer_high <= `BCM_BYTE_RST;
      data_pointer_low <= `BCM_BYTE_RST;
    end else begin
      if (push_wr) begin
        sp <= sp_inc;
      end else if (wr_sp) begin
        sp <= wr_data;
      end
      if (in_exec & op_data_pointer) begin
        data_pointer_high <= b1;
        data_pointer_low <= b2;
      end else begin
        if (wr_dph) begin
          data_pointer_high <= wr_data;
        end
        if (wr_dpl) begin
          data_pointer_low <= wr_data;
        end
      end
    end
  end

  // ==========================================================
  // outside special registers and completion
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sfr_we_o    <= 1'b0;
      sfr_addr_o  <= `BCM_BYTE_RST;
      sfr_wdata_o <= `BCM_BYTE_RST;
      insn_done_o <= 1'b0;
    end else begin
      sfr_we_o    <= wr_ext;
      sfr_addr_o  <= wr_ext ? wr_addr : sfr_addr_o;
      sfr_wdata_o <= wr_ext ? wr_data : sfr_wdata_o;
      insn_done_o <= (state == BCM_ST_PAD) & mc_done;
    end
  end

endmodule : bcm_branch_call_move_executor

`default_nettype wire

// *** tb/bcm_exec_monitor.sv ***
// port assertions of the branch, call and move executor
`timescale 1ns/1ps
`default_nettype none

module bcm_exec_monitor (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               arst_n_i,
  // observed ports
  input  wire bcm_pkg::bcm_byte_t rom_data_i,
  input  wire logic               sfr_we_o,
  input  wire logic [7:0]         sfr_addr_o,
  input  wire logic [7:0]         acc_o,
  input  wire logic [7:0]         psw_o,
  input  wire logic [7:0]         sp_o,
  input  wire logic               insn_done_o
);
  import bcm_pkg::*;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // ==========================================================
  // sequences
  sequence op_start(logic [7:0] op);
    insn_done_o && rom_data_i == op;
  endsequence

  sequence rel_start;
    insn_done_o && rom_data_i inside {8'h30, 8'h50, 8'h60, 8'h70};
  endsequence

  // ==========================================================
  // assertions
  done_gap_a: assert property (insn_done_o |=> !insn_done_o [*3])
    else $error("instruction ends closer than one machine cycle");
  bit_jump_len_a: assert property (op_start(8'h30) |-> ##16 insn_done_o)
    else $error("bit clear jump not four machine cycles");
  carry_jump_len_a: assert property (op_start(8'h50) |-> ##12 insn_done_o)
    else $error("carry clear jump not three machine cycles");
  flags_kept_a: assert property (rel_start |=> $stable(psw_o) [*8])
    else $error("status word changed by a relative jump");
  acc_kept_a: assert property (rel_start |=> $stable(acc_o) [*8])
    else $error("accumulator changed by a relative jump");
  call_stack_a: assert property (op_start(8'h12) |-> ##16 sp_o == $past(sp_o, 16) + 8'h02)
    else $error("long call did not raise stack index by two");
  long_jump_len_a: assert property (op_start(8'h02) |-> ##16 insn_done_o)
    else $error("long jump not four machine cycles");
  pointer_len_a: assert property (op_start(8'h90) |-> ##12 insn_done_o)
    else $error("data pointer load not three machine cycles");
  acc_imm_len_a: assert property (op_start(8'h74) |-> ##8 insn_done_o)
    else $error("accumulator load not two machine cycles");
  reg_imm_len_a: assert property (insn_done_o && rom_data_i[7:3] == 5'h0F |-> ##8 insn_done_o)
    else $error("register load not two machine cycles");
  outside_pulse_a: assert property (sfr_we_o |=> !sfr_we_o)
    else $error("outside register write longer than one clock");
  outside_addr_a: assert property (sfr_we_o |-> sfr_addr_o[7])
    else $error("outside register write below special area");
endmodule : bcm_exec_monitor

bind bcm_branch_call_move_executor bcm_exec_monitor u_mon (
  .mclk_i      (mclk_i),
  .arst_n_i    (arst_n_i),
  .rom_data_i  (rom_data_i),
  .sfr_we_o    (sfr_we_o),
  .sfr_addr_o  (sfr_addr_o),
  .acc_o       (acc_o),
  .psw_o       (psw_o),
  .sp_o        (sp_o),
  .insn_done_o (insn_done_o)
);

`default_nettype wire

// *** tb/bcm_rom_model.sv ***
// combinational program memory model
`timescale 1ns/1ps
`default_nettype none

module bcm_rom_model (
  // program memory port
  input  wire logic [15:0]       addr_i,
  output var bcm_pkg::bcm_byte_t data_o
);
  import bcm_pkg::*;

  bcm_byte_t mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  assign data_o = mem[addr_i];
endmodule : bcm_rom_model

`default_nettype wire

// *** tb/test_branch_call_move_executor.sv ***
// testbench of the branch, call and move executor
`timescale 1ns/1ps
`default_nettype none

module test_branch_call_move_executor;
  import bcm_pkg::*;

  logic        mclk_i;
  logic        arst_n_i;
  logic [15:0] rom_addr_o;
  bcm_byte_t   rom_data_i;
  logic        sfr_we_o;
  logic [7:0]  sfr_addr_o;
  logic [7:0]  sfr_wdata_o;
  logic [15:0] pc_o;
  logic [7:0]  acc_o;
  logic [7:0]  psw_o;
  logic [7:0]  sp_o;
  logic [15:0] data_pointer_o;
  logic        insn_done_o;
  logic [15:0] pa;
  logic [15:0] wcnt;
  logic [7:0]  wa;
  logic [7:0]  wd;
  int          fail_count;
  int          comparisons;

  // ==========================================================
  // design and program memory
  bcm_branch_call_move_executor DUT (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .rom_addr_o(rom_addr_o),
    .rom_data_i(rom_data_i), .sfr_we_o(sfr_we_o), .sfr_addr_o(sfr_addr_o),
    .sfr_wdata_o(sfr_wdata_o), .pc_o(pc_o), .acc_o(acc_o), .psw_o(psw_o),
    .sp_o(sp_o), .data_pointer_o(data_pointer_o), .insn_done_o(insn_done_o)
  );
  bcm_rom_model rom (.addr_i(rom_addr_o), .data_o(rom_data_i));

  always #2.5 mclk_i = ~mclk_i;

  // outside register writes seen
  always @(posedge mclk_i) begin
    if (sfr_we_o === 1'b1) begin
      wcnt <= wcnt + 16'h0001;
      wa   <= sfr_addr_o;
      wd   <= sfr_wdata_o;
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic code(input logic [23:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      rom.mem[pa] = w[23 - 8 * i -: 8];
      pa++;
    end
  endtask : code

  task automatic step(input int mc);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (insn_done_o !== 1'b1 && n < 40);
    if (mc > 0) begin
      chk(16'(n), 16'(4 * mc));
    end else begin
      chk(16'(insn_done_o), 16'h0001);
    end
  endtask : step

  task automatic load_program;
    pa = 16'h0000;
    code(24'h740000, 2);
    code(24'h600300, 2);
    code(24'h000000, 3);
    code(24'h700500, 2);
    code(24'h748000, 2);
    code(24'h700200, 2);
    code(24'h000000, 2);
    code(24'h601000, 2);
    code(24'h752001, 3);
    code(24'hA20000, 2);
    code(24'h507F00, 2);
    code(24'h920100, 2);
    code(24'hE52000, 2);
    code(24'hA20200, 2);
    code(24'h500200, 2);
    code(24'h000000, 2);
    code(24'h30007F, 3);
    code(24'h300203, 3);
    code(24'h000000, 3);
    code(24'hE52000, 2);
    code(24'h7A1100, 2);
    code(24'h8A3000, 2);
    code(24'h853031, 3);
    code(24'hE53100, 2);
    code(24'h75D008, 3);
    code(24'h7A2200, 2);
    code(24'hE50A00, 2);
    code(24'hE50200, 2);
    code(24'h901234, 3);
    code(24'h75905A, 3);
    code(24'h120200, 3);
    pa = 16'h0200;
    code(24'hE50800, 2);
    code(24'hE50900, 2);
    code(24'h020210, 3);
    code(24'h020300, 3);
    pa = 16'h0210;
    code(24'h60F500, 2);
    pa = 16'h0300;
    code(24'h75D000, 3);
    code(24'h784000, 2);
    code(24'h745C00, 2);
    code(24'hF60000, 1);
    code(24'h740000, 2);
    code(24'hE60000, 1);
    code(24'hA63100, 2);
    code(24'hE60000, 1);
    code(24'h767700, 2);
    code(24'h86F000, 2);
    code(24'hE5F000, 2);
    code(24'hFB0000, 1);
    code(24'h740000, 2);
    code(24'hEB0000, 1);
    code(24'hAC3000, 2);
    code(24'hF58300, 2);
    code(24'h8C8200, 2);
    code(24'h92E000, 2);
    code(24'h758130, 3);
    code(24'h020323, 3);
  endtask : load_program

  // ==========================================================
  // scenarios
  task automatic s_acc_jumps;
    step(0);
    chk(acc_o, 8'h00);
    step(3);
    chk(pc_o, 16'h0007);
    step(3);
    chk(pc_o, 16'h0009);
    step(2);
    chk(acc_o, 8'h80);
    step(3);
    chk(pc_o, 16'h000F);
    step(3);
    chk(pc_o, 16'h0011);
  endtask : s_acc_jumps

  task automatic s_bit_carry;
    step(3);
    step(2);
    chk(psw_o, 8'h80);
    step(3);
    chk(pc_o, 16'h0018);
    chk(psw_o, 8'h80);
    step(2);
    step(2);
    chk(acc_o, 8'h03);
    step(2);
    chk(psw_o, 8'h00);
    step(3);
    chk(pc_o, 16'h0022);
    step(4);
    chk(pc_o, 16'h0025);
    step(4);
    chk(pc_o, 16'h002B);
    step(2);
    chk(acc_o, 8'h03);
    chk(psw_o, 8'h00);
  endtask : s_bit_carry

  task automatic s_reg_moves;
    step(2);
    step(2);
    step(3);
    step(2);
    chk(acc_o, 8'h11);
    step(3);
    chk(psw_o, 8'h08);
    step(2);
    step(2);
    chk(acc_o, 8'h22);
    step(2);
    chk(acc_o, 8'h11);
  endtask : s_reg_moves

  task automatic s_data_pointer_sfr;
    step(3);
    chk(data_pointer_o, 16'h1234);
    step(3);
    chk(wcnt, 16'h0001);
    chk(wa, 8'h90);
    chk(wd, 8'h5A);
  endtask : s_data_pointer_sfr

  task automatic s_call_jump;
    step(4);
    chk(pc_o, 16'h0200);
    chk(sp_o, 8'h09);
    chk(rom_addr_o, 16'h0200);
    step(2);
    chk(acc_o, 8'h48);
    step(2);
    chk(acc_o, 8'h00);
    step(4);
    chk(pc_o, 16'h0210);
    step(3);
    chk(pc_o, 16'h0207);
    step(4);
    chk(pc_o, 16'h0300);
  endtask : s_call_jump

  task automatic s_ind_moves;
    step(3);
    step(2);
    step(2);
    step(1);
    step(2);
    step(1);
    chk(acc_o, 8'h5C);
    step(2);
    step(1);
    chk(acc_o, 8'h11);
    step(2);
    step(2);
    step(2);
    chk(acc_o, 8'h77);
    step(1);
    step(2);
    step(1);
    chk(acc_o, 8'h77);
    step(2);
    step(2);
    chk(data_pointer_o, 16'h7734);
    step(2);
    chk(data_pointer_o, 16'h7711);
    step(2);
    chk(acc_o, 8'h76);
    step(3);
    chk(sp_o, 8'h30);
    step(4);
    chk(pc_o, 16'h0323);
  endtask : s_ind_moves

  task automatic end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // main sequence and watchdog
  initial begin
    mclk_i = 1'b0;
    arst_n_i = 1'b0;
    wcnt = 16'h0000;
    fail_count = 0;
    comparisons = 0;
    @(posedge mclk_i);
    load_program();
    repeat (19) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    s_acc_jumps();
    s_bit_carry();
    s_reg_moves();
    s_data_pointer_sfr();
    s_call_jump();
    s_ind_moves();
    end_of_test();
  end

  initial begin
    #10000;
    fail_count++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : test_branch_call_move_executor

`default_nettype wire
